// File: rtl/pcs_top.sv
// port pins and clock source selection for a small controller
// assumes a register master on clock_i and asynchronous pins
//
// Local design decisions: strobed register access and the address map.
module pcs_top #(
  parameter int SUB_DIV = pcs_pkg::SUB_DIV
) (
  input wire logic clock_i,
  input wire logic srst_i,
  // register port
  input wire logic [pcs_pkg::ADDR_W-1:0] addr_i,
  input wire logic [pcs_pkg::DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [pcs_pkg::DATA_W-1:0] rdata_o,
  output logic irq_o,
  // clock enables
  output logic machine_base_clock_o,
  output logic instr_cycle_clock_o,
  // reset pin and its causes
  input wire logic wdt_expire_i,
  input wire logic low_supply_i,
  input wire logic reset_pin_i,
  output logic reset_pin_o,
  output logic reset_pin_oe_n_o,
  // single bit outputs
  input wire logic [7:0] single_bit_outputs_i,
  output logic [7:0] single_bit_outputs_o,
  output logic [7:0] single_bit_outputs_oe_n_o,
  output logic sub_osc_out_sel_o,
  output logic ext_int_o,
  // key ports
  input wire logic [3:0] key_port_a_i,
  output logic [3:0] key_port_a_o,
  output logic [3:0] key_port_a_oe_n_o,
  output logic [3:0] key_port_a_pu_o,
  input wire logic [3:0] key_port_b_i,
  output logic [3:0] key_port_b_o,
  output logic [3:0] key_port_b_oe_n_o,
  output logic [3:0] key_port_b_pu_o,
  output logic key_wake_o,
  // input port shared with segments
  input wire logic [3:0] shared_segment_outs_i,
  input wire logic [3:0] input_port_c_i,
  output logic [3:0] input_port_c_o,
  output logic [3:0] input_port_c_oe_n_o,
  // common line use
  output logic [3:0] lcd_common_lines_o
);
  import pcs_pkg::*;

  logic [3:0] clock_mode_reg_q;
  logic [2:0] dptr_q;
  logic [7:0] dlat_q;
  logic [3:0] pa_lat_q;
  logic [3:0] pb_lat_q;
  logic [3:0] pullup_ctrl_reg_q;
  logic kwb_en_q;
  logic [3:0] segsel_q;
  logic subsel_q;
  logic [1:0] duty_q;
  logic [3:0] stat_q;
  logic [3:0] mask_q;
  logic [DATA_W-1:0] rdata_q;
  logic [$clog2(RST_LOW_CYC+1)-1:0] rst_cnt_q;
  logic [3:0] pa_lvl;
  logic [3:0] pb_lvl;
  logic [3:0] pc_lvl;
  logic [7:0] d_lvl;
  logic [3:0] pa_prev_q;
  logic [3:0] pb_prev_q;
  logic int_prev_q;
  logic [3:0] ev;
  logic [3:0] key_fall;
  logic int_fall;
  logic wsel;

  assign wsel = wr_i;

  // one synchroniser for every pin that is read back
  pcs_sync #(.W(20), .INIT(20'hfffff)) pcs_sync_i (
    .clock_i(clock_i),
    .srst_i(srst_i),
    .pin_i({single_bit_outputs_i, input_port_c_i, key_port_b_i, key_port_a_i}),
    .level_o({d_lvl, pc_lvl, pb_lvl, pa_lvl})
  );

  // clock enable generator
  pcs_clkgen #(.SUB_DIV(SUB_DIV)) pcs_clkgen_i (
    .clock_i(clock_i),
    .srst_i(srst_i),
    .use_sub_i(clock_mode_reg_q[MODE_SRC_BIT]),
    .div4_i(clock_mode_reg_q[MODE_DIV_BIT]),
    .sys_tick_o(machine_base_clock_o),
    .instr_tick_o(instr_cycle_clock_o)
  );

  // clock mode register, main over four after reset
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      clock_mode_reg_q <= MODE_RST;
    end else if (wsel && addr_i == OFS_MODE) begin
      clock_mode_reg_q <= wdata_i[3:0];
    end
  end

  // bit pointer for single bit writes
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      dptr_q <= '0;
    end else if (wsel && addr_i == OFS_DPTR) begin
      dptr_q <= wdata_i[2:0];
    end
  end

  // single bit latches: one bit per write, or all cleared
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      dlat_q <= DLAT_RST;
    end else if (wsel && addr_i == OFS_DBIT) begin
      dlat_q[dptr_q] <= wdata_i[0];
    end else if (wsel && addr_i == OFS_DALL) begin
      dlat_q <= '0;
    end
  end

  // key port latches
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      pa_lat_q <= PLAT_RST;
      pb_lat_q <= PLAT_RST;
    end else if (wsel && addr_i == OFS_PA) begin
      pa_lat_q <= wdata_i[3:0];
    end else if (wsel && addr_i == OFS_PB) begin
      pb_lat_q <= wdata_i[3:0];
    end
  end

  // second port pull-up and wakeup controls
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      pullup_ctrl_reg_q <= '0;
      kwb_en_q <= 1'b0;
    end else if (wsel && addr_i == OFS_PUB) begin
      pullup_ctrl_reg_q <= wdata_i[3:0];
    end else if (wsel && addr_i == OFS_KWB) begin
      kwb_en_q <= wdata_i[0];
    end
  end

  // pin function selects and duty
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      segsel_q <= '0;
      subsel_q <= 1'b0;
      duty_q <= DUTY_QUARTER;
    end else if (wsel && addr_i == OFS_SEGSEL) begin
      segsel_q <= wdata_i[3:0];
    end else if (wsel && addr_i == OFS_SUBSEL) begin
      subsel_q <= wdata_i[0];
    end else if (wsel && addr_i == OFS_DUTY) begin
      duty_q <= wdata_i[1:0];
    end
  end

  // open-drain outputs drive low only where the latch holds zero
  always_comb begin
    single_bit_outputs_o = '0;
    single_bit_outputs_oe_n_o = dlat_q;
    if (subsel_q) begin
      single_bit_outputs_oe_n_o[7:6] = 2'h3;
    end
  end
  assign sub_osc_out_sel_o = subsel_q;
  assign key_port_a_o = '0;
  assign key_port_a_oe_n_o = pa_lat_q;
  assign key_port_b_o = '0;
  assign key_port_b_oe_n_o = pb_lat_q;
  assign key_port_a_pu_o = 4'hf;
  assign key_port_b_pu_o = pullup_ctrl_reg_q;

  // shared pins drive segment data only when selected
  assign input_port_c_o = shared_segment_outs_i & segsel_q;
  assign input_port_c_oe_n_o = ~segsel_q;

  // common lines in use for each duty
  always_comb begin
    unique case (duty_q)
      DUTY_HALF: lcd_common_lines_o = 4'h3;
      DUTY_THIRD: lcd_common_lines_o = 4'h7;
      DUTY_QUARTER: lcd_common_lines_o = 4'hf;
      default: lcd_common_lines_o = 4'hf;
    endcase
  end

  // reset pin held low while a cause stands and a while after
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      rst_cnt_q <= '0;
    end else if (wdt_expire_i || low_supply_i) begin
      rst_cnt_q <= ($bits(rst_cnt_q))'(RST_LOW_CYC);
    end else if (rst_cnt_q != '0) begin
      rst_cnt_q <= rst_cnt_q - 1'b1;
    end
  end
  assign reset_pin_o = 1'b0;
  assign reset_pin_oe_n_o = (rst_cnt_q == '0);

  // falling edge detection on filtered levels
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      pa_prev_q <= '1;
      pb_prev_q <= '1;
      int_prev_q <= 1'b1;
    end else begin
      pa_prev_q <= pa_lvl;
      pb_prev_q <= pb_lvl;
      int_prev_q <= d_lvl[INT_BIT];
    end
  end
  assign key_fall = (pa_prev_q & ~pa_lvl & pa_lat_q)
    | ({4{kwb_en_q}} & pb_prev_q & ~pb_lvl & pb_lat_q);
  assign int_fall = int_prev_q && !d_lvl[INT_BIT] && dlat_q[INT_BIT];
  assign key_wake_o = |key_fall;
  assign ext_int_o = int_fall;
  assign ev = {low_supply_i, wdt_expire_i, int_fall, |key_fall};

  // sticky status, write one to clear, a new event wins
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      stat_q <= '0;
    end else if (wsel && addr_i == OFS_STAT) begin
      stat_q <= (stat_q & ~wdata_i[3:0]) | ev;
    end else begin
      stat_q <= stat_q | ev;
    end
  end

  // interrupt mask
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      mask_q <= '0;
    end else if (wsel && addr_i == OFS_MASK) begin
      mask_q <= wdata_i[3:0];
    end
  end
  assign irq_o = |(stat_q & mask_q);

  // read data registered for the cycle after the strobe
  always_ff @(posedge clock_i) begin
    if (srst_i || !rd_i) begin
      rdata_q <= '0;
    end else begin
      unique case (addr_i)
        OFS_MODE: rdata_q <= {4'h0, clock_mode_reg_q};
        OFS_DPTR: rdata_q <= {5'h0, dptr_q};
        OFS_DBIT: rdata_q <= dlat_q;
        OFS_PA: rdata_q <= {4'h0, pa_lvl};
        OFS_PB: rdata_q <= {4'h0, pb_lvl};
        OFS_PUB: rdata_q <= {4'h0, pullup_ctrl_reg_q};
        OFS_KWB: rdata_q <= {7'h0, kwb_en_q};
        OFS_PC: rdata_q <= {4'h0, pc_lvl};
        OFS_SEGSEL: rdata_q <= {4'h0, segsel_q};
        OFS_SUBSEL: rdata_q <= {7'h0, subsel_q};
        OFS_DUTY: rdata_q <= {6'h0, duty_q};
        OFS_STAT: rdata_q <= {4'h0, stat_q};
        OFS_MASK: rdata_q <= {4'h0, mask_q};
        default: rdata_q <= '0;
      endcase
    end
  end
  assign rdata_o = rdata_q;

  reset_mode_a: assert property (@(posedge clock_i)
    $fell(srst_i) |-> clock_mode_reg_q == MODE_RST)
    else $error("clock mode not main over four after reset");
  mode_write_a: assert property (@(posedge clock_i) disable iff (srst_i)
    (wr_i && addr_i == OFS_MODE) |=> clock_mode_reg_q == $past(wdata_i[3:0]))
    else $error("clock mode write lost");
  reset_drive_a: assert property (@(posedge clock_i) disable iff (srst_i)
    (wdt_expire_i || low_supply_i) |=> !reset_pin_oe_n_o [*2])
    else $error("reset pin not driven low");
  single_bit_a: assert property (@(posedge clock_i) disable iff (srst_i)
    (wr_i && addr_i == OFS_DBIT) |=>
      ((dlat_q ^ $past(dlat_q)) & ~(8'h1 << $past(dptr_q))) == '0)
    else $error("single bit write touched another bit");
  sub_pins_a: assert property (@(posedge clock_i) disable iff (srst_i)
    subsel_q |-> single_bit_outputs_oe_n_o[7:6] == 2'h3)
    else $error("sub oscillator pins still driven");
  port_release_a: assert property (@(posedge clock_i) disable iff (srst_i)
    (wr_i && addr_i == OFS_PA && wdata_i[0]) |=> key_port_a_oe_n_o[0])
    else $error("port pin driven with latch one");
  pullup_b_a: assert property (@(posedge clock_i) disable iff (srst_i)
    (wr_i && addr_i == OFS_PUB) |=> key_port_b_pu_o == $past(wdata_i[3:0]))
    else $error("pull-up control not applied");
  seg_select_a: assert property (@(posedge clock_i) disable iff (srst_i)
    input_port_c_oe_n_o == ~segsel_q)
    else $error("segment select mismatch");
  duty_half_a: assert property (@(posedge clock_i) disable iff (srst_i)
    duty_q == DUTY_HALF |-> lcd_common_lines_o == 4'h3)
    else $error("half duty commons wrong");
  released_a: assert property (@(posedge clock_i)
    $fell(srst_i) |-> (&single_bit_outputs_oe_n_o) && (&key_port_a_oe_n_o)
      && (&key_port_b_oe_n_o))
    else $error("pin driven after reset");
  read_pins_a: assert property (@(posedge clock_i) disable iff (srst_i)
    (rd_i && addr_i == OFS_PB) |=> rdata_o[3:0] == $past(pb_lvl))
    else $error("port read not pin level");
  read_latch_a: assert property (@(posedge clock_i) disable iff (srst_i)
    (rd_i && addr_i == OFS_DBIT) |=> rdata_o == $past(dlat_q))
    else $error("single bit latch read wrong");
  duty_third_a: assert property (@(posedge clock_i) disable iff (srst_i)
    duty_q == DUTY_THIRD |-> lcd_common_lines_o == 4'h7)
    else $error("third duty commons wrong");
  duty_quarter_a: assert property (@(posedge clock_i) disable iff (srst_i)
    duty_q == DUTY_QUARTER |-> lcd_common_lines_o == 4'hf)
    else $error("quarter duty commons wrong");
  key_status_a: assert property (@(posedge clock_i) disable iff (srst_i)
    key_wake_o |=> stat_q[ST_KEY])
    else $error("key wakeup not recorded");
  key_sticky_a: assert property (@(posedge clock_i) disable iff (srst_i)
    (stat_q[ST_KEY] && !(wr_i && addr_i == OFS_STAT && wdata_i[ST_KEY])) |=> stat_q[ST_KEY])
    else $error("key status lost without clear");
  wake_off_a: assert property (@(posedge clock_i) disable iff (srst_i)
    (!kwb_en_q && pa_prev_q == pa_lvl) |-> !key_wake_o)
    else $error("second port woke while disabled");
endmodule

// File: rtl/pcs_pkg.sv
// constants for the port and clock select block
// assumes a single 125 MHz clock and a plain register port
package pcs_pkg;
  localparam int ADDR_W = 6;
  localparam int DATA_W = 8;
  localparam int CLK_PERIOD_NS = 8;
  // register byte offsets
  localparam logic [5:0] OFS_MODE = 6'h00;
  localparam logic [5:0] OFS_DPTR = 6'h04;
  localparam logic [5:0] OFS_DBIT = 6'h08;
  localparam logic [5:0] OFS_DALL = 6'h0c;
  localparam logic [5:0] OFS_PA = 6'h10;
  localparam logic [5:0] OFS_PB = 6'h14;
  localparam logic [5:0] OFS_PUB = 6'h18;
  localparam logic [5:0] OFS_KWB = 6'h1c;
  localparam logic [5:0] OFS_PC = 6'h20;
  localparam logic [5:0] OFS_SEGSEL = 6'h24;
  localparam logic [5:0] OFS_SUBSEL = 6'h28;
  localparam logic [5:0] OFS_DUTY = 6'h2c;
  localparam logic [5:0] OFS_STAT = 6'h30;
  localparam logic [5:0] OFS_MASK = 6'h34;
  // clock mode field positions and reset value
  localparam int MODE_SRC_BIT = 0;
  localparam int MODE_DIV_BIT = 3;
  localparam logic [3:0] MODE_RST = 4'h8;
  // latch reset values: all ones keep open-drain pins released
  localparam logic [7:0] DLAT_RST = 8'hff;
  localparam logic [3:0] PLAT_RST = 4'hf;
  // status bits, then the single bit line that carries the interrupt pin
  localparam int ST_KEY = 0;
  localparam int ST_INT = 1;
  localparam int ST_WDT = 2;
  localparam int ST_LVD = 3;
  localparam int INT_BIT = 5;
  // duty codes
  localparam logic [1:0] DUTY_HALF = 2'h0;
  localparam logic [1:0] DUTY_THIRD = 2'h1;
  localparam logic [1:0] DUTY_QUARTER = 2'h2;
  // timing
  localparam int SRC_DIV = 4;
  localparam int INSTR_DIV = 3;
  localparam int SUB_DIV = 3906;
  localparam int RST_LOW_NS = 1000;
  localparam int RST_LOW_CYC = (RST_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

// File: rtl/pcs_sync.sv
// three-stage pin synchroniser with agreement filter
// assumes pins are asynchronous to clock_i
module pcs_sync #(
  parameter int W = 4,
  parameter logic [W-1:0] INIT = '1
) (
  input wire logic clock_i,
  input wire logic srst_i,
  input wire logic [W-1:0] pin_i,
  output logic [W-1:0] level_o
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  // shift chain; first stage feeds only the second
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      s1_q <= INIT;
      s2_q <= INIT;
      s3_q <= INIT;
    end else begin
      s1_q <= pin_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // accept a bit once stages two and three agree
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      always_ff @(posedge clock_i) begin
        if (srst_i) begin
          level_o[g] <= INIT[g];
        end else if (s2_q[g] == s3_q[g]) begin
          level_o[g] <= s3_q[g];
        end
      end
    end
  endgenerate
endmodule

// File: rtl/pcs_clkgen.sv
// system and instruction clock enables from main or sub source
// assumes clock_i is the main oscillator rate
module pcs_clkgen #(
  parameter int SUB_DIV = pcs_pkg::SUB_DIV
) (
  input wire logic clock_i,
  input wire logic srst_i,
  input wire logic use_sub_i,
  input wire logic div4_i,
  output logic sys_tick_o,
  output logic instr_tick_o
);
  import pcs_pkg::*;
  localparam int SW = $clog2(SUB_DIV);
  logic [SW-1:0] sub_cnt_q;
  logic [1:0] div4_q;
  logic [1:0] div3_q;
  logic sub_tick;
  logic src_tick;
  logic sys_tick;

  // sub oscillator rate as a divided enable
  always_ff @(posedge clock_i) begin
    if (srst_i || sub_cnt_q == SW'(SUB_DIV - 1)) begin
      sub_cnt_q <= '0;
    end else begin
      sub_cnt_q <= sub_cnt_q + 1'b1;
    end
  end
  assign sub_tick = (sub_cnt_q == SW'(SUB_DIV - 1));
  assign src_tick = use_sub_i ? sub_tick : 1'b1;

  // optional divide by four of the chosen source
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      div4_q <= '0;
    end else if (src_tick) begin
      div4_q <= div4_q + 1'b1;
    end
  end
  assign sys_tick = div4_i ? (src_tick && div4_q == 2'(SRC_DIV - 1)) : src_tick;

  // instruction clock is system clock over three
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      div3_q <= '0;
    end else if (sys_tick) begin
      div3_q <= (div3_q == 2'(INSTR_DIV - 1)) ? 2'h0 : div3_q + 1'b1;
    end
  end
  assign sys_tick_o = sys_tick;
  assign instr_tick_o = sys_tick && div3_q == 2'(INSTR_DIV - 1);

  instr_on_sys_a: assert property (@(posedge clock_i) disable iff (srst_i)
    instr_tick_o |-> sys_tick_o)
    else $error("instruction tick without system tick");
  main_div4_gap_a: assert property (@(posedge clock_i) disable iff (srst_i)
    (sys_tick_o && div4_i && !use_sub_i && $stable(div4_i) && $stable(use_sub_i))
      |=> (!sys_tick_o || !div4_i || use_sub_i)[*3]
      ##1 (sys_tick_o || !div4_i || use_sub_i))
    else $error("main divided by four spacing wrong");
  main_full_a: assert property (@(posedge clock_i) disable iff (srst_i)
    (!div4_i && !use_sub_i) |-> sys_tick_o)
    else $error("undivided main clock missed a tick");
endmodule

// File: bench/pcs_pins.sv
// pin loads for the port block: keys, interrupt source, board pull-ups
// assumes every open-drain enable is low while the block drives its pin
module pcs_pins (
  input wire logic clock_i,
  input wire logic [7:0] d_oe_n_i,
  input wire logic [3:0] a_oe_n_i,
  input wire logic [3:0] b_oe_n_i,
  input wire logic [3:0] b_pu_i,
  input wire logic [3:0] c_drv_i,
  input wire logic [3:0] c_oe_n_i,
  input wire logic rst_oe_n_i,
  input wire logic int_low_i,
  input wire logic [3:0] key_a_i,
  input wire logic [3:0] key_b_i,
  input wire logic [3:0] c_ext_i,
  output logic [7:0] d_o,
  output logic [3:0] a_o,
  output logic [3:0] b_o,
  output logic [3:0] c_o,
  output logic rst_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] float_q = 4'h0;
  // a released line with no pull-up wanders every cycle
  always @(posedge clock_i) float_q <= ~float_q;
  // board pull-ups on single bit lines, interrupt source pulls bit five
  assign d_o = d_oe_n_i & ~{2'h0, int_low_i, 5'h00};
  // port a keeps its pull-up, a pressed key shorts the pin low
  assign a_o = a_oe_n_i & ~key_a_i;
  assign b_o = b_oe_n_i & ~key_b_i & (b_pu_i | float_q);
  // segment drive where selected, else the outside source
  assign c_o = (~c_oe_n_i & c_drv_i) | (c_oe_n_i & c_ext_i);
  assign rst_o = rst_oe_n_i; // built-in pull-up on the reset line
endmodule

// File: bench/test_port_and_clock_select.sv
// self-checking bench for the port and clock select block
// assumes the pin model in pcs_pins and a sub clock divider of 4
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin errors++; \
  $display("wrong value %s exp %0h got %0h", n, (e), (s)); end end
module test_port_and_clock_select;
  timeunit 1ns;
  timeprecision 100ps;
  import pcs_pkg::*;
  localparam int SUBD = 4;
  logic clock_i = 0, srst_i = 1, wr_i = 0, rd_i = 0, wdt = 0, lvd = 0, int_low = 0;
  logic [5:0] addr_i = 0;
  logic [7:0] wdata_i = 0, rdata_o, d_pin, d_out, d_oe_n, v8;
  logic irq, sys_t, ins_t, rpin, rpin_o, rpin_oe_n, sub_sel, ext_int, kwake, hit;
  logic [3:0] a_pin, a_out, a_oe_n, a_pu, b_pin, b_out, b_oe_n, b_pu, c_pin, c_out;
  logic [3:0] c_oe_n, coms, seg = 0, key_a = 0, key_b = 0, c_ext = 0;
  int errors = 0, check_count = 0, seed = 14, dl, i, m, p, v;
  // 125 MHz clock
  always #4 clock_i = ~clock_i;
  pcs_top #(.SUB_DIV(SUBD)) pcs_top_i (
    .clock_i(clock_i), .srst_i(srst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq),
    .machine_base_clock_o(sys_t), .instr_cycle_clock_o(ins_t),
    .wdt_expire_i(wdt), .low_supply_i(lvd), .reset_pin_i(rpin),
    .reset_pin_o(rpin_o), .reset_pin_oe_n_o(rpin_oe_n),
    .single_bit_outputs_i(d_pin), .single_bit_outputs_o(d_out),
    .single_bit_outputs_oe_n_o(d_oe_n), .sub_osc_out_sel_o(sub_sel), .ext_int_o(ext_int),
    .key_port_a_i(a_pin), .key_port_a_o(a_out), .key_port_a_oe_n_o(a_oe_n),
    .key_port_a_pu_o(a_pu), .key_port_b_i(b_pin), .key_port_b_o(b_out),
    .key_port_b_oe_n_o(b_oe_n), .key_port_b_pu_o(b_pu), .key_wake_o(kwake),
    .shared_segment_outs_i(seg), .input_port_c_i(c_pin), .input_port_c_o(c_out),
    .input_port_c_oe_n_o(c_oe_n), .lcd_common_lines_o(coms)
  );
  pcs_pins pcs_pins_i (
    .clock_i(clock_i), .d_oe_n_i(d_oe_n), .a_oe_n_i(a_oe_n), .b_oe_n_i(b_oe_n),
    .b_pu_i(b_pu), .c_drv_i(c_out), .c_oe_n_i(c_oe_n), .rst_oe_n_i(rpin_oe_n),
    .int_low_i(int_low), .key_a_i(key_a), .key_b_i(key_b), .c_ext_i(c_ext),
    .d_o(d_pin), .a_o(a_pin), .b_o(b_pin), .c_o(c_pin), .rst_o(rpin)
  );
  // verdict and end of run
  task automatic finish_test;
    if (errors == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // register port cycles
  task automatic wr_reg(input logic [5:0] a, input logic [7:0] d);
    @(posedge clock_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clock_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd_reg(input logic [5:0] a, output logic [7:0] d);
    @(posedge clock_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clock_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask
  task automatic tick;
    @(posedge clock_i);
    #1;
  endtask
  // cycles between two enable pulses, bounded
  task automatic per(input bit ins, output int n);
    int k, t0;
    t0 = -1;
    n = -1;
    for (k = 0; k < 200 && n < 0; k++) begin
      tick;
      if (ins ? ins_t : sys_t) begin
        if (t0 >= 0) n = k - t0;
        t0 = k;
      end
    end
    if (n < 0) begin
      errors++;
      finish_test;
    end
  endtask
  // look for an event pulse within a short window
  task automatic waitev(input bit ext, output logic h);
    h = 1'b0;
    for (int k = 0; k < 12 && h !== 1'b1; k++) begin
      tick;
      h = ext ? ext_int : kwake;
    end
  endtask
  // hang guard
  initial begin
    #400000;
    errors++;
    finish_test;
  end
  // main sequence
  initial begin
    repeat (5) @(posedge clock_i);
    srst_i <= 1'b0;
    tick;
    `CHK("d_oe_n", 8'hff, d_oe_n)
    `CHK("a_oe_n", 4'hf, a_oe_n)
    `CHK("b_oe_n", 4'hf, b_oe_n)
    rd_reg(OFS_MODE, v8);
    `CHK("mode", 8'h08, v8)
    per(0, p);
    per(0, p);
    `CHK("reset sys period", 4, p)
    for (m = 0; m < 4; m++) begin
      wr_reg(OFS_MODE, {4'h0, m[1], 2'h0, m[0]});
      per(0, p);
      per(0, p);
      `CHK("sys period", (m[0] ? SUBD : 1) * (m[1] ? 4 : 1), p)
      per(1, p);
      `CHK("instr period", 3 * (m[0] ? SUBD : 1) * (m[1] ? 4 : 1), p)
    end
    wr_reg(OFS_PUB, 8'h0f);
    wr_reg(OFS_KWB, 8'h01);
    // single bit latches set one at a time
    dl = 8'hff;
    for (i = 0; i < 12; i++) begin
      p = $random(seed) & 7;
      v = $random(seed) & 1;
      wr_reg(OFS_DPTR, p[7:0]);
      wr_reg(OFS_DBIT, v[7:0]);
      dl[p] = v[0];
      tick;
      `CHK("d_oe_n", dl[7:0], d_oe_n)
    end
    rd_reg(OFS_DBIT, v8);
    `CHK("d latches", dl[7:0], v8)
    wr_reg(OFS_DALL, 8'h00);
    tick;
    `CHK("d cleared", 8'h00, d_oe_n)
    // interrupt line on bit five needs its latch released
    wr_reg(OFS_DPTR, 8'h05);
    wr_reg(OFS_DBIT, 8'h01);
    repeat (8) @(posedge clock_i);
    wr_reg(OFS_STAT, 8'hff);
    wr_reg(OFS_MASK, 8'h02);
    int_low <= 1'b1;
    waitev(1, hit);
    `CHK("ext int", 1'b1, hit)
    tick;
    `CHK("irq int", 1'b1, irq)
    @(posedge clock_i);
    int_low <= 1'b0;
    wr_reg(OFS_STAT, 8'h02);
    tick;
    `CHK("irq cleared", 1'b0, irq)
    // port latches and pin reads
    for (i = 0; i < 6; i++) begin
      v = $random(seed);
      wr_reg(OFS_PUB, {4'h0, v[11:8]});
      tick;
      `CHK("b pull-up", v[11:8], b_pu)
      `CHK("a pull-up", 4'hf, a_pu)
      wr_reg(OFS_PUB, 8'h0f);
      wr_reg(OFS_PA, {4'h0, v[3:0]});
      wr_reg(OFS_PB, {4'h0, v[7:4]});
      repeat (6) @(posedge clock_i);
      `CHK("a_oe_n", v[3:0], a_oe_n)
      `CHK("b_oe_n", v[7:4], b_oe_n)
      rd_reg(OFS_PA, v8);
      `CHK("a pins", {4'h0, v[3:0]}, v8)
      rd_reg(OFS_PB, v8);
      `CHK("b pins", {4'h0, v[7:4]}, v8)
    end
    // key wakeup on both ports, then port b switched off
    wr_reg(OFS_PA, 8'h0f);
    wr_reg(OFS_PB, 8'h0f);
    repeat (8) @(posedge clock_i);
    wr_reg(OFS_STAT, 8'hff);
    wr_reg(OFS_MASK, 8'h01);
    for (i = 0; i < 3; i++) begin
      if (i == 2) wr_reg(OFS_KWB, 8'h00);
      if (i == 0) key_a <= 4'h2;
      else key_b <= 4'h4;
      waitev(0, hit);
      `CHK("key wake", (i < 2), hit)
      tick;
      `CHK("irq key", (i < 2), irq)
      @(posedge clock_i);
      key_a <= 4'h0;
      key_b <= 4'h0;
      repeat (8) @(posedge clock_i);
      wr_reg(OFS_STAT, 8'h01);
    end
    // shared input and segment pins
    seg <= $random(seed);
    c_ext <= $random(seed);
    v = $random(seed) & 15;
    wr_reg(OFS_SEGSEL, v[7:0]);
    repeat (6) @(posedge clock_i);
    `CHK("c_oe_n", ~v[3:0], c_oe_n)
    `CHK("c seg", seg & v[3:0], c_out)
    rd_reg(OFS_PC, v8);
    `CHK("c pins", {4'h0, (seg & v[3:0]) | (c_ext & ~v[3:0])}, v8)
    for (m = 0; m < 4; m++) begin
      wr_reg(OFS_DUTY, m[7:0]);
      tick;
      `CHK("commons", (m == 0) ? 4'h3 : (m == 1) ? 4'h7 : 4'hf, coms)
    end
    wr_reg(OFS_SUBSEL, 8'h01);
    tick;
    `CHK("sub osc sel", 1'b1, sub_sel)
    `CHK("sub pins", 2'h3, d_oe_n[7:6])
    `CHK("drive levels", 17'h0, {rpin_o, d_out, a_out, b_out})
    // reset line driven low from either cause
    wr_reg(OFS_MASK, 8'h00);
    for (i = 0; i < 2; i++) begin
      @(posedge clock_i);
      {lvd, wdt} <= i ? 2'b10 : 2'b01;
      @(posedge clock_i);
      {lvd, wdt} <= 2'b00;
      tick;
      `CHK("reset pin", 1'b0, rpin)
      repeat (RST_LOW_CYC - 2) tick;
      `CHK("reset held", 1'b0, rpin_oe_n)
      tick;
      `CHK("reset freed", 1'b1, rpin_oe_n)
      rd_reg(OFS_STAT, v8);
      `CHK("cause status", 1'b1, v8[ST_WDT + i])
      `CHK("irq masked", 1'b0, irq)
    end
    rd_reg(6'h3c, v8);
    `CHK("unmapped", 8'h00, v8)
    finish_test;
  end
endmodule
